/* File: src/dsc_pkg.sv */
package dsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // serial frame layout: read flag, address, data, msb first
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned READ_BIT   = 23;
    localparam int unsigned ADDR_HI    = 20;
    localparam int unsigned ADDR_LO    = 16;
    localparam int unsigned DATA_HI    = 15;
    localparam int unsigned DATA_LO    = 0;

    localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
    localparam logic [CNT_W-1:0] CNT_OVER = 5'h19;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses inside the frame
    localparam logic [ADDR_W-1:0] ADDR_DAC_INPUT = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG    = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_OUTPUT    = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_SW_RESET  = 5'h05;

    localparam logic [DATA_W-1:0] SW_RESET_KEY   = 16'h5a5a;

    ////////////////////////////////////////////////////////////////////////////////
    // general_config_one fields and reset values
    localparam int unsigned CFG_CLK_EN_BIT = 0;
    localparam int unsigned CFG_DIV_LO     = 1;
    localparam int unsigned CFG_DIV_HI     = 3;
    localparam int unsigned CFG_MODEM_BIT  = 4;
    localparam logic [DATA_W-1:0] CFG_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] CFG_MASK     = 16'h001f;
    localparam logic [DATA_W-1:0] CODE_RESET   = 16'h0000;

    localparam int unsigned STATUS_FRAME_ERR_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator emulation: fractional accumulator gives the 10 MHz tick
    localparam int unsigned SYS_CLK_HZ  = 125_000_000;
    localparam int unsigned OSC_HZ      = 10_000_000;
    localparam int unsigned OSC_GCD_HZ  = 5_000_000;
    localparam int unsigned ACC_W       = 5;
    localparam logic [ACC_W-1:0] OSC_ACC_STEP = ACC_W'(OSC_HZ / OSC_GCD_HZ);
    localparam logic [ACC_W-1:0] OSC_ACC_MOD  = ACC_W'(SYS_CLK_HZ / OSC_GCD_HZ);
    localparam int unsigned PRE_W       = 8;

    typedef enum logic [0:0] {
        DSC_IDLE  = 1'b0,
        DSC_SHIFT = 1'b1
    } dsc_state_t;

endpackage

/* File: src/dsc_link_if.sv */
`timescale 1ns/1ps
interface dsc_link_if;
    import dsc_pkg::*;
    logic                  hold;
    logic [FRAME_BITS-1:0] rd_word;
    logic [FRAME_BITS-1:0] frame_word;
    logic                  frame_done;
    logic                  frame_ok;
    logic                  sdo;

    modport shifter (input hold, input rd_word,
                     output frame_word, output frame_done, output frame_ok, output sdo);
    modport core    (output hold, output rd_word,
                     input frame_word, input frame_done, input frame_ok, input sdo);
endinterface

/* File: src/dsc_shifter.sv */
`timescale 1ns/1ps
module dsc_shifter
    import dsc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       sclk,
    input  wire logic       sdi,
    input  wire logic       sync_n,
    dsc_link_if.shifter     link
);

    logic                  sclk_prev_reg;
    logic                  sclk_fall;
    logic                  sclk_rise;
    dsc_state_t            state_reg;
    logic [FRAME_BITS-1:0] in_reg;
    logic [FRAME_BITS-1:0] out_reg;
    logic [CNT_W-1:0]      cnt_reg;
    logic [FRAME_BITS-1:0] frame_word_reg;
    logic                  frame_done_reg;
    logic                  frame_ok_reg;
    logic                  sdo_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection on the sampled shift clock
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // matches the idle low level of the shift clock, so no false edge follows reset
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk;
        end
    end

    assign sclk_fall = sclk_prev_reg & ~sclk;
    assign sclk_rise = ~sclk_prev_reg & sclk;

    ////////////////////////////////////////////////////////////////////////////////
    // frame capture
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg      <= DSC_IDLE;
            in_reg         <= '0;
            cnt_reg        <= '0;
            frame_word_reg <= '0;
            frame_done_reg <= 1'b0;
            frame_ok_reg   <= 1'b0;
        end else if (link.hold) begin
            // shift clock activity is ignored while reset is requested
            state_reg      <= DSC_IDLE;
            in_reg         <= '0;
            cnt_reg        <= '0;
            frame_done_reg <= 1'b0;
            frame_ok_reg   <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            case (state_reg)
                DSC_IDLE: begin
                    if (!sync_n) begin
                        state_reg <= DSC_SHIFT;
                        cnt_reg   <= '0;
                    end
                end
                DSC_SHIFT: begin
                    if (sync_n) begin
                        state_reg      <= DSC_IDLE;
                        frame_done_reg <= 1'b1;
                        frame_ok_reg   <= (cnt_reg == CNT_FULL);
                        frame_word_reg <= in_reg;
                    end else if (sclk_fall) begin
                        // sdi is taken in the cycle the falling edge is seen
                        in_reg <= {in_reg[FRAME_BITS-2:0], sdi};
                        if (cnt_reg != CNT_OVER) begin
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                    end
                end
                default: begin
                    state_reg <= DSC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback output: msb at frame start, next bit on each rising edge after the first, zeros after
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= '0;
            sdo_reg <= 1'b0;
        end else if (link.hold) begin
            out_reg <= '0;
            sdo_reg <= 1'b0;
        end else if (state_reg == DSC_IDLE && !sync_n) begin
            sdo_reg <= link.rd_word[FRAME_BITS-1];
            out_reg <= {link.rd_word[FRAME_BITS-2:0], 1'b0};
        end else if (state_reg == DSC_SHIFT && !sync_n && sclk_rise && cnt_reg != '0) begin
            sdo_reg <= out_reg[FRAME_BITS-1];
            out_reg <= {out_reg[FRAME_BITS-2:0], 1'b0};
        end else if (sync_n) begin
            // idle line sits low so a stale last bit is not taken for data
            out_reg <= '0;
            sdo_reg <= 1'b0;
        end
    end

    assign link.frame_word = frame_word_reg;
    assign link.frame_done = frame_done_reg;
    assign link.frame_ok   = frame_ok_reg;
    assign link.sdo        = sdo_reg;

endmodule

/* File: src/dsc_top.sv */
`timescale 1ns/1ps

// Function
// - serial input bits enter the input shift register on each shift clock falling edge.
// - in readback the serial register leaves on the data output one bit per shift clock.
// - a low level on the hardware reset input requests a reset.
// - while the load strobe is low the output code register takes the staged code.
// - the clock output is off after reset and, when enabled, is the divided oscillator.
// - the modem coupling input is disconnected after reset and connected only when enabled.
// - frame select is active low and data is accepted only while it is low.
// - the open-drain alarm pulls low on a detected fault and floats otherwise.
module dsc_top
    import dsc_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    input  wire logic                      sclk,
    input  wire logic                      sdi,
    input  wire logic                      sync_n,
    input  wire logic                      load_output_n,
    input  wire logic                      hw_reset_n,
    output logic                           sdo,
    output logic                           divided_clock_out,
    output logic                           modem_path_enable,
    output logic [dsc_pkg::DATA_W-1:0]     output_code,
    output logic                           alarm_o,
    output logic                           alarm_oe
);
    import dsc_pkg::*;

    dsc_link_if link ();

    logic [DATA_W-1:0]     staged_code_reg;
    logic [DATA_W-1:0]     output_code_reg;
    logic [DATA_W-1:0]     config_reg;
    logic                  fault_reg;
    logic                  sw_reset_reg;
    logic [FRAME_BITS-1:0] rd_word_reg;
    logic                  alarm_o_reg;
    logic [ACC_W-1:0]      osc_acc_reg;
    logic                  osc_tick_reg;
    logic [PRE_W-1:0]      prescale_reg;
    logic                  dclk_reg;
    logic                  rst_req;
    logic                  frame_write;
    logic                  frame_read;
    logic [ADDR_W-1:0]     frame_addr;
    logic [DATA_W-1:0]     frame_data;
    logic [DATA_W-1:0]     read_data;
    logic [2:0]            div_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // serial shifter
    dsc_shifter u_shifter (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .sclk    (sclk),
        .sdi     (sdi),
        .sync_n  (sync_n),
        .link    (link.shifter)
    );

    // pin reset and the keyed software reset act alike
    assign rst_req   = ~hw_reset_n | sw_reset_reg;
    assign link.hold = rst_req;

    assign frame_addr  = link.frame_word[ADDR_HI:ADDR_LO];
    assign frame_data  = link.frame_word[DATA_HI:DATA_LO];
    assign frame_write = link.frame_done & link.frame_ok & ~link.frame_word[READ_BIT];
    assign frame_read  = link.frame_done & link.frame_ok &  link.frame_word[READ_BIT];

    always_comb begin
        read_data = '0;
        case (frame_addr)
            ADDR_DAC_INPUT: read_data = staged_code_reg;
            ADDR_CONFIG:    read_data = config_reg;
            ADDR_STATUS:    read_data = {{(DATA_W-1){1'b0}}, fault_reg};
            ADDR_OUTPUT:    read_data = output_code_reg;
            default:        read_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software reset: one cycle pulse, taken only with the right key
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sw_reset_reg <= 1'b0;
        end else if (sw_reset_reg) begin
            sw_reset_reg <= 1'b0;
        end else begin
            sw_reset_reg <= frame_write && frame_addr == ADDR_SW_RESET
                            && frame_data == SW_RESET_KEY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            staged_code_reg <= CODE_RESET;
            config_reg      <= CFG_RESET;
        end else if (rst_req) begin
            staged_code_reg <= CODE_RESET;
            config_reg      <= CFG_RESET;
        end else if (frame_write) begin
            if (frame_addr == ADDR_DAC_INPUT) begin
                staged_code_reg <= frame_data;
            end
            if (frame_addr == ADDR_CONFIG) begin
                config_reg <= frame_data & CFG_MASK;
            end
        end
    end

    // level sensitive load: the output tracks the staged code while the strobe is low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            output_code_reg <= CODE_RESET;
        end else if (rst_req) begin
            output_code_reg <= CODE_RESET;
        end else if (!load_output_n) begin
            output_code_reg <= staged_code_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback word presented during the frame after a read command, else zeros
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_word_reg <= '0;
        end else if (rst_req) begin
            rd_word_reg <= '0;
        end else if (frame_read) begin
            rd_word_reg <= {3'h0, frame_addr, read_data};
        end else if (link.frame_done) begin
            rd_word_reg <= '0;
        end
    end

    assign link.rd_word = rd_word_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // fault: a frame of wrong length; a status read clears it, a new error wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_reg <= 1'b0;
        end else if (rst_req) begin
            fault_reg <= 1'b0;
        end else if (link.frame_done && !link.frame_ok) begin
            fault_reg <= 1'b1;
        end else if (frame_read && frame_addr == ADDR_STATUS) begin
            fault_reg <= 1'b0;
        end
    end

    // open drain: data is always low, the enable carries the fault
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alarm_o_reg <= 1'b0;
        end else begin
            alarm_o_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator tick: 2/25 of sys_clk gives 10 MHz on average, with 12/13 cycle jitter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            osc_acc_reg  <= '0;
            osc_tick_reg <= 1'b0;
        end else if (osc_acc_reg + OSC_ACC_STEP >= OSC_ACC_MOD) begin
            osc_acc_reg  <= osc_acc_reg + OSC_ACC_STEP - OSC_ACC_MOD;
            osc_tick_reg <= 1'b1;
        end else begin
            osc_acc_reg  <= osc_acc_reg + OSC_ACC_STEP;
            osc_tick_reg <= 1'b0;
        end
    end

    assign div_sel = config_reg[CFG_DIV_HI:CFG_DIV_LO];

    // divided clock: prescaler bit div_sel gives oscillator / 2^(div_sel+1)
    // limitation: changing div_sel while enabled can cut one phase short,
    // so software should disable the output before picking a new divider
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prescale_reg <= '0;
            dclk_reg     <= 1'b0;
        end else if (!config_reg[CFG_CLK_EN_BIT]) begin
            prescale_reg <= '0;
            dclk_reg     <= 1'b0;
        end else begin
            if (osc_tick_reg) begin
                prescale_reg <= prescale_reg + 8'h01;
            end
            dclk_reg <= prescale_reg[div_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign sdo               = link.sdo;
    assign divided_clock_out = dclk_reg;
    assign modem_path_enable = config_reg[CFG_MODEM_BIT];
    assign output_code       = output_code_reg;
    assign alarm_o           = alarm_o_reg;
    assign alarm_oe          = fault_reg;

endmodule

/* File: test/dsc_assertions.sv */
`timescale 1ns/1ps
module dsc_assertions
    import dsc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              sclk,
    input wire logic              sdi,
    input wire logic              sync_n,
    input wire logic              load_output_n,
    input wire logic              hw_reset_n,
    input wire logic              sdo,
    input wire logic              divided_clock_out,
    input wire logic              modem_path_enable,
    input wire logic [DATA_W-1:0] output_code,
    input wire logic              alarm_o,
    input wire logic              alarm_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////////
    property p_reset_clear;
        !hw_reset_n [*2] |=> output_code == CODE_RESET && !modem_path_enable
            && !divided_clock_out && !alarm_oe;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("state survived a held reset");
    property p_code_cause;
        $changed(output_code) |-> !$past(load_output_n) || !$past(load_output_n, 2)
            || !$past(hw_reset_n) || !$past(hw_reset_n, 2);
    endproperty
    a_code_cause: assert property (p_code_cause)
        else $error("output code moved without load");
    property p_modem_cause;
        $changed(modem_path_enable) |-> ($past(sync_n) && $past(sync_n, 2))
            || !$past(hw_reset_n) || !$past(hw_reset_n, 2);
    endproperty
    a_modem_cause: assert property (p_modem_cause)
        else $error("modem path moved inside a frame");
    property p_alarm_cause;
        $rose(alarm_oe) |-> $past(sync_n) && $past(sync_n, 2);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("alarm raised inside a frame");
    property p_alarm_level;
        !alarm_o;
    endproperty
    a_alarm_level: assert property (p_alarm_level)
        else $error("open drain alarm drove high");
    property p_sdo_idle;
        sync_n [*4] |-> !sdo;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("data out busy outside a frame");
    property p_sdo_cause;
        $changed(sdo) |-> !($past(sync_n) && $past(sync_n, 2) && $past(sync_n, 3));
    endproperty
    a_sdo_cause: assert property (p_sdo_cause)
        else $error("data out moved while idle");
    property p_div_low;
        $fell(divided_clock_out) |-> !divided_clock_out [*8];
    endproperty
    a_div_low: assert property (p_div_low)
        else $error("divided clock low phase too short");
endmodule

/* File: test/dsc_host_model.sv */
`timescale 1ns/1ps
module dsc_host_model
    import dsc_pkg::*;
#(
    parameter int HALF = 5
)(
    input  wire logic sys_clk,
    output logic      sclk,
    output logic      sdi,
    output logic      sync_n,
    input  wire logic sdo
);
    initial begin
        sclk   = 1'b0;
        sdi    = 1'b0;
        sync_n = 1'b1;
    end

    // half period of 5 cycles gives 12.5 MHz, slow enough for readback too
    task automatic frame(input logic [FRAME_BITS-1:0] w, input int nbits,
                         output logic [FRAME_BITS-1:0] rd);
        rd = '0;
        @(posedge sys_clk);
        sync_n <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
            sclk <= 1'b1;
            sdi  <= w[FRAME_BITS-1-i];
            repeat (HALF) @(posedge sys_clk);
            rd = {rd[FRAME_BITS-2:0], sdo};
            sclk <= 1'b0;
            repeat (HALF) @(posedge sys_clk);
        end
        sync_n <= 1'b1;
        // a released line must not keep showing the last bit
        sdi <= ~sdi;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import dsc_pkg::*;
    logic                  sys_clk;
    logic                  resetn;
    logic                  load_output_n;
    logic                  hw_reset_n;
    logic                  sclk;
    logic                  sdi;
    logic                  sync_n;
    logic                  sdo;
    logic                  divided_clock_out;
    logic                  modem_path_enable;
    logic [DATA_W-1:0]     output_code;
    logic                  alarm_o;
    logic                  alarm_oe;
    logic [FRAME_BITS-1:0] rd;
    int                    n_mismatch;
    int                    comparisons;

    dsc_top u_dsc_top (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .sdi(sdi),
        .sync_n(sync_n), .load_output_n(load_output_n), .hw_reset_n(hw_reset_n), .sdo(sdo),
        .divided_clock_out(divided_clock_out), .modem_path_enable(modem_path_enable),
        .output_code(output_code), .alarm_o(alarm_o), .alarm_oe(alarm_oe));
    dsc_host_model u_dsc_host_model (.sys_clk(sys_clk), .sclk(sclk), .sdi(sdi),
        .sync_n(sync_n), .sdo(sdo));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic xfer(input logic rf, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input int nbits);
        u_dsc_host_model.frame({rf, 2'b00, a, d}, nbits, rd);
    endtask
    task automatic check_bit(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic check_word(input logic [FRAME_BITS-1:0] got,
                              input logic [FRAME_BITS-1:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        check_word({8'h00, output_code}, 24'h000000, "code after reset");
        check_bit(modem_path_enable, 1'b0, "modem after reset");
        check_bit(divided_clock_out, 1'b0, "clock out after reset");
        check_bit(alarm_oe, 1'b0, "alarm after reset");
    endtask
    task automatic t_config();
        xfer(1'b0, ADDR_CONFIG, 16'h0010, 24);
        check_bit(modem_path_enable, 1'b1, "modem enable");
        xfer(1'b0, ADDR_CONFIG, 16'h0000, 24);
        check_bit(modem_path_enable, 1'b0, "modem disable");
    endtask
    task automatic t_load();
        xfer(1'b0, ADDR_DAC_INPUT, 16'ha5c3, 24);
        wait_clk(200);
        check_word({8'h00, output_code}, 24'h000000, "code moved without load");
        load_output_n <= 1'b0;
        wait_clk(3);
        load_output_n <= 1'b1;
        wait_clk(2);
        check_word({8'h00, output_code}, 24'h00a5c3, "code after load");
        xfer(1'b1, ADDR_OUTPUT, 16'h0000, 24);
        xfer(1'b0, ADDR_DAC_INPUT, 16'h1234, 24);
        check_word(rd, {3'b000, ADDR_OUTPUT, 16'ha5c3}, "output readback");
        check_word({8'h00, output_code}, 24'h00a5c3, "code held");
    endtask
    task automatic t_fault();
        xfer(1'b0, ADDR_CONFIG, 16'h0010, 23);
        check_bit(modem_path_enable, 1'b0, "short frame applied");
        check_bit(alarm_oe, 1'b1, "alarm not pulled");
        check_bit(alarm_o, 1'b0, "alarm level");
        xfer(1'b1, ADDR_STATUS, 16'h0000, 24);
        xfer(1'b1, 5'h1f, 16'h0000, 24);
        check_word(rd, {3'b000, ADDR_STATUS, 16'h0001}, "status readback");
        check_bit(alarm_oe, 1'b0, "alarm not released");
        xfer(1'b0, 5'h1f, 16'h0000, 24);
        check_word(rd, {3'b000, 5'h1f, 16'h0000}, "unmapped readback");
    endtask
    task automatic t_divclk();
        int n;
        int exp;
        logic prev;
        for (int i = 0; i < 3; i++) begin
            // restart the prescaler so no shortened phase appears at the switch
            xfer(1'b0, ADDR_CONFIG, 16'h0000, 24);
            xfer(1'b0, ADDR_CONFIG, 16'(i * 2 + 1), 24);
            n = 0;
            exp = 600 / (25 << i);
            prev = divided_clock_out;
            repeat (600) begin
                @(posedge sys_clk);
                if (divided_clock_out && !prev)
                    n++;
                prev = divided_clock_out;
            end
            check_bit(n >= exp - 1 && n <= exp + 1, 1'b1, "divider rate");
        end
        xfer(1'b0, ADDR_CONFIG, 16'h0000, 24);
        check_bit(divided_clock_out, 1'b0, "clock out disable");
    endtask
    task automatic t_hw_reset();
        xfer(1'b0, ADDR_CONFIG, 16'h0010, 24);
        check_bit(modem_path_enable, 1'b1, "modem before reset");
        hw_reset_n <= 1'b0;
        xfer(1'b0, ADDR_CONFIG, 16'h0010, 24);
        hw_reset_n <= 1'b1;
        wait_clk(2);
        check_bit(modem_path_enable, 1'b0, "modem after pin reset");
        check_word({8'h00, output_code}, 24'h000000, "code after pin reset");
        wait_clk(12500);
        xfer(1'b1, ADDR_CONFIG, 16'h0000, 24);
        xfer(1'b0, 5'h1f, 16'h0000, 24);
        check_word(rd, {3'b000, ADDR_CONFIG, CFG_RESET}, "config default");
    endtask
    task automatic t_sw_reset();
        xfer(1'b0, ADDR_DAC_INPUT, 16'h0f0f, 24);
        xfer(1'b0, ADDR_CONFIG, 16'h0010, 24);
        xfer(1'b0, ADDR_SW_RESET, 16'h0000, 24);
        check_bit(modem_path_enable, 1'b1, "soft reset without key");
        xfer(1'b1, ADDR_DAC_INPUT, 16'h0000, 24);
        xfer(1'b0, ADDR_SW_RESET, SW_RESET_KEY, 24);
        check_word(rd, {3'b000, ADDR_DAC_INPUT, 16'h0f0f}, "staged readback");
        check_bit(modem_path_enable, 1'b0, "modem after soft reset");
        wait_clk(12500);
        xfer(1'b1, ADDR_DAC_INPUT, 16'h0000, 24);
        xfer(1'b0, 5'h1f, 16'h0000, 24);
        check_word(rd, {3'b000, ADDR_DAC_INPUT, CODE_RESET}, "staged cleared");
    endtask

    initial begin
        resetn        = 1'b0;
        load_output_n = 1'b1;
        hw_reset_n    = 1'b1;
        n_mismatch    = 0;
        comparisons   = 0;
        wait_clk(6);
        resetn <= 1'b1;
        wait_clk(2);
        t_reset_values();
        wait_clk(12500);
        t_config();
        t_load();
        t_fault();
        t_divclk();
        t_hw_reset();
        t_sw_reset();
        stop_test();
    end

    // the sequence needs about 46000 cycles
    initial begin
        wait_clk(90000);
        n_mismatch++;
        stop_test();
    end
endmodule

bind dsc_top dsc_assertions u_dsc_assertions (.sys_clk(sys_clk), .resetn(resetn),
    .sclk(sclk), .sdi(sdi), .sync_n(sync_n), .load_output_n(load_output_n),
    .hw_reset_n(hw_reset_n), .sdo(sdo), .divided_clock_out(divided_clock_out),
    .modem_path_enable(modem_path_enable), .output_code(output_code),
    .alarm_o(alarm_o), .alarm_oe(alarm_oe));
